// ==== rtl/usbcaf_consts.vh ====
/*
 * Constants of the USB control, address and frame-number register slice:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef USBCAF_CONSTS_VH
`define USBCAF_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define UCAF_OFF_CTRL 8'h00
`define UCAF_OFF_ADDR 8'h04
`define UCAF_OFF_FRAME_LOW_BYTE 8'h08
`define UCAF_OFF_FRAME_HIGH_BITS 8'h0C

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define UCAF_CTRL_ENABLE 0
`define UCAF_CTRL_PPRST 1
`define UCAF_CTRL_RESUME 2
`define UCAF_CTRL_HOST 3
`define UCAF_CTRL_BUSRST 4
`define UCAF_CTRL_PACKET_PROCESSING_DISABLE 5
`define UCAF_CTRL_SE0 6
`define UCAF_CTRL_JSTATE 7

// Address register fields
`define UCAF_ADDR_LS 7
`define UCAF_ADDR_DEV_HI 6
`define UCAF_ADDR_DEV_LO 0

// Frame number split
`define UCAF_FRAME_HIGH_BITS_HI 10
`define UCAF_FRAME_HIGH_BITS_LO 8
`define UCAF_FRAME_LOW_BYTE_HI 7
`define UCAF_FRAME_LOW_BYTE_LO 0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define UCAF_CTRL_RST 6'h00
`define UCAF_ADDR_RST 8'h00
`define UCAF_FRAME_RST 11'h000

// AXI responses
`define UCAF_RESP_OKAY 2'h0
`define UCAF_RESP_SLVERR 2'h2

////////////////////////////////////////////////////////////////////////////////
// Timing
`define UCAF_CLK_NS 10
`define UCAF_SOF_PERIOD_NS 1000000
`define UCAF_SOF_CYC (`UCAF_SOF_PERIOD_NS / `UCAF_CLK_NS)
`define UCAF_LS_EOP_NS 1334
`define UCAF_LS_EOP_CYC ((`UCAF_LS_EOP_NS + `UCAF_CLK_NS - 1) / `UCAF_CLK_NS)

`endif

// ==== rtl/usbcaf_host_timer.v ====
/*
 * Host-side timing: the 1 ms frame-start tick and the low-speed
 * end-of-packet that closes resume signalling.
 * Assumes a synchronous one-cycle host reset pulse from the register slice.
 */
`timescale 1ns/1ns
`default_nettype none
`include "usbcaf_consts.vh"

module usbcaf_host_timer #(
	parameter [31:0] SOF_CYC = `UCAF_SOF_CYC,
	parameter [31:0] EOP_CYC = `UCAF_LS_EOP_CYC
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Control
	input wire host_reset_i,
	input wire sof_enable_i,
	input wire resume_fall_i,
	// Results
	output reg sof_tick_o,
	output reg ls_eop_o
);

localparam [16:0] SOF_LAST = SOF_CYC[16:0] - 17'h00001;
localparam [7:0] EOP_LAST = EOP_CYC[7:0] - 8'h01;

reg [16:0] sof_cnt_q;
reg [7:0] eop_cnt_q;

////////////////////////////////////////////////////////////////////////////////
// Frame-start period; restarts whenever generation is off
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		sof_cnt_q <= 17'h00000;
		sof_tick_o <= 1'b0;
	end else if (host_reset_i || !sof_enable_i) begin
		sof_cnt_q <= 17'h00000;
		sof_tick_o <= 1'b0;
	end else if (sof_cnt_q == SOF_LAST) begin
		sof_cnt_q <= 17'h00000;
		sof_tick_o <= 1'b1;
	end else begin
		sof_cnt_q <= sof_cnt_q + 17'h00001;
		sof_tick_o <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Low-speed EOP window after resume is dropped
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		eop_cnt_q <= 8'h00;
		ls_eop_o <= 1'b0;
	end else if (host_reset_i) begin
		eop_cnt_q <= 8'h00;
		ls_eop_o <= 1'b0;
	end else if (resume_fall_i) begin
		eop_cnt_q <= 8'h00;
		ls_eop_o <= 1'b1;
	end else if (ls_eop_o) begin
		if (eop_cnt_q == EOP_LAST) begin
			ls_eop_o <= 1'b0;
		end
		eop_cnt_q <= eop_cnt_q + 8'h01;
	end
end

endmodule
`default_nettype wire

// ==== rtl/usbcaf_regs.v ====
/*
 * USB control, device address and frame-number registers behind an
 * AXI4-Lite slave, with mode-dependent control outputs to the USB engine.
 * Assumes the packet engine reports token activity, SETUP receipt and
 * received frame numbers synchronously to clock_i.
 */
// Design decisions made here: the register offsets and register access over AXI4-Lite.
// Behaviour
// - Writing one to control bit 1 sends all ping-pong pointers to even bank.
// - Device mode: control bit 0 enables the USB module and its circuitry.
// - Host mode: control bit 0 enables a frame-start token every millisecond.
// - Any toggle of the host enable bit resets all host control logic.
// - Host mode: clearing resume appends a low-speed end-of-packet on the bus.
// - Address bit 7 makes the next token run at low speed, else full speed.
// - Address bits 6 to 0 hold the device address, read/write, reset zero.
// - Frame low register shows frame bits 7..0, reloaded on each received SOF while control bit 0 or host mode is set.
// - Frame high register shows frame bits 10..8, updated with the low byte.
// - Unimplemented bits read zero: 31..3 in frame high, 31..8 elsewhere.
// - Host mode: token-busy reads one while a token executes, else zero.
// - Device mode: a received SETUP sets packet-disable, halting token processing.
`timescale 1ns/1ns
`default_nettype none
`include "usbcaf_consts.vh"

module usbcaf_regs #(
	parameter [31:0] SOF_CYC = `UCAF_SOF_CYC
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// USB engine status
	input wire jstate_i,
	input wire se0_i,
	input wire token_busy_i,
	input wire setup_rx_i,
	input wire sof_rx_i,
	input wire [10:0] sof_frame_i,
	// USB engine control
	output reg module_enable_o,
	output reg pingpong_reset_o,
	output reg resume_o,
	output reg bus_reset_o,
	output reg host_mode_o,
	output reg host_logic_reset_o,
	output reg packet_disable_o,
	output reg low_speed_next_token_o,
	output reg [6:0] device_address_o,
	output wire sof_tick_o,
	output wire ls_eop_o
);

// Register index returned by the decoder
localparam [2:0] REG_CTRL = 3'h0;
localparam [2:0] REG_ADDR = 3'h1;
localparam [2:0] REG_FRAME_LOW_BYTE = 3'h2;
localparam [2:0] REG_FRAME_HIGH_BITS = 3'h3;
localparam [2:0] REG_NONE = 3'h4;

// Control register storage, bits 5..0 (bits 7,6 are live inputs)
reg [5:0] ctrl_q;
reg [5:0] ctrl_d;
reg [7:0] addr_q;
reg [10:0] frame_q;
reg host_prev_q;
reg resume_prev_q;

// Write channel holding
reg aw_have_q;
reg w_have_q;
reg [7:0] aw_addr_q;
reg [7:0] w_data_q;
reg w_lane0_q;

wire wr_fire;
wire [2:0] wr_sel;
wire [2:0] rd_sel;
wire host_reset_pulse;
wire resume_fall;
wire usb_active;
wire ctrl_wr;
wire addr_wr;
reg [7:0] rd_byte;

////////////////////////////////////////////////////////////////////////////////
// Address decode shared by both directions; word-aligned, low bits ignored
function [2:0] reg_decode;
	input [7:0] addr;
	reg [7:0] word;
	begin
		word = {addr[7:2], 2'h0};
		if (word == `UCAF_OFF_CTRL) begin
			reg_decode = REG_CTRL;
		end else if (word == `UCAF_OFF_ADDR) begin
			reg_decode = REG_ADDR;
		end else if (word == `UCAF_OFF_FRAME_LOW_BYTE) begin
			reg_decode = REG_FRAME_LOW_BYTE;
		end else if (word == `UCAF_OFF_FRAME_HIGH_BITS) begin
			reg_decode = REG_FRAME_HIGH_BITS;
		end else begin
			reg_decode = REG_NONE;
		end
	end
endfunction

// Register write strobe; a cleared low byte lane leaves the register alone
function wr_hit;
	input fire;
	input lane;
	input [2:0] sel;
	input [2:0] target;
	begin
		wr_hit = fire && lane && (sel == target);
	end
endfunction

// Unmapped offsets answer with a slave error and change nothing
function [1:0] resp_code;
	input [2:0] sel;
	begin
		if (sel == REG_NONE) begin
			resp_code = `UCAF_RESP_SLVERR;
		end else begin
			resp_code = `UCAF_RESP_OKAY;
		end
	end
endfunction

assign wr_sel = reg_decode(aw_addr_q);
assign rd_sel = reg_decode(s_axi_araddr);
// Write happens once both halves are held and no response is pending
assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
assign ctrl_wr = wr_hit(wr_fire, w_lane0_q, wr_sel, REG_CTRL);
assign addr_wr = wr_hit(wr_fire, w_lane0_q, wr_sel, REG_ADDR);

////////////////////////////////////////////////////////////////////////////////
// Write address and data capture, in either order
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		aw_have_q <= 1'b0;
		w_have_q <= 1'b0;
		aw_addr_q <= 8'h00;
		w_data_q <= 8'h00;
		w_lane0_q <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata[7:0];
			w_lane0_q <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
		// Ready only while the holding slot is free; one cycle pulse per beat
		s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
		s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Write response
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `UCAF_RESP_OKAY;
	end else if (wr_fire) begin
		s_axi_bvalid <= 1'b1;
		s_axi_bresp <= resp_code(wr_sel);
	end else if (s_axi_bready) begin
		s_axi_bvalid <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control register next value
always @* begin
	ctrl_d = ctrl_q;
	if (ctrl_wr) begin
		ctrl_d = w_data_q[5:0];
		// Packet-disable is host-read-only busy in host mode
		if (ctrl_q[`UCAF_CTRL_HOST]) begin
			ctrl_d[`UCAF_CTRL_PACKET_PROCESSING_DISABLE] = ctrl_q[`UCAF_CTRL_PACKET_PROCESSING_DISABLE];
		end
	end
	// A SETUP arriving with a software clear still sets the bit
	if (setup_rx_i && !ctrl_q[`UCAF_CTRL_HOST]) begin
		ctrl_d[`UCAF_CTRL_PACKET_PROCESSING_DISABLE] = 1'b1;
	end
end

always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		ctrl_q <= `UCAF_CTRL_RST;
		host_prev_q <= 1'b0;
		resume_prev_q <= 1'b0;
	end else begin
		ctrl_q <= ctrl_d;
		host_prev_q <= ctrl_q[`UCAF_CTRL_HOST];
		resume_prev_q <= ctrl_q[`UCAF_CTRL_RESUME];
	end
end

assign host_reset_pulse = host_prev_q != ctrl_q[`UCAF_CTRL_HOST];
// Only a host drops resume with a trailing low-speed EOP
assign resume_fall = resume_prev_q && !ctrl_q[`UCAF_CTRL_RESUME] &&
	ctrl_q[`UCAF_CTRL_HOST];
assign usb_active = ctrl_q[`UCAF_CTRL_ENABLE] || ctrl_q[`UCAF_CTRL_HOST];

////////////////////////////////////////////////////////////////////////////////
// Address register
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		addr_q <= `UCAF_ADDR_RST;
	end else if (addr_wr) begin
		addr_q <= w_data_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Frame number, captured whole so both halves always match
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		frame_q <= `UCAF_FRAME_RST;
	end else if (sof_rx_i && usb_active) begin
		frame_q <= sof_frame_i;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read path; frame registers ignore writes
always @* begin
	rd_byte = 8'h00;
	if (rd_sel == REG_CTRL) begin
		rd_byte[`UCAF_CTRL_JSTATE] = jstate_i;
		rd_byte[`UCAF_CTRL_SE0] = se0_i;
		rd_byte[`UCAF_CTRL_BUSRST] = ctrl_q[`UCAF_CTRL_BUSRST];
		rd_byte[`UCAF_CTRL_HOST] = ctrl_q[`UCAF_CTRL_HOST];
		rd_byte[`UCAF_CTRL_RESUME] = ctrl_q[`UCAF_CTRL_RESUME];
		rd_byte[`UCAF_CTRL_PPRST] = ctrl_q[`UCAF_CTRL_PPRST];
		rd_byte[`UCAF_CTRL_ENABLE] = ctrl_q[`UCAF_CTRL_ENABLE];
		if (ctrl_q[`UCAF_CTRL_HOST]) begin
			// Lets software hold off token writes while busy
			rd_byte[`UCAF_CTRL_PACKET_PROCESSING_DISABLE] = token_busy_i;
		end else begin
			rd_byte[`UCAF_CTRL_PACKET_PROCESSING_DISABLE] = ctrl_q[`UCAF_CTRL_PACKET_PROCESSING_DISABLE];
		end
	end else if (rd_sel == REG_ADDR) begin
		rd_byte = addr_q;
	end else if (rd_sel == REG_FRAME_LOW_BYTE) begin
		rd_byte = frame_q[`UCAF_FRAME_LOW_BYTE_HI:`UCAF_FRAME_LOW_BYTE_LO];
	end else if (rd_sel == REG_FRAME_HIGH_BITS) begin
		rd_byte = {5'h00, frame_q[`UCAF_FRAME_HIGH_BITS_HI:`UCAF_FRAME_HIGH_BITS_LO]};
	end
end

always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `UCAF_RESP_OKAY;
	end else begin
		s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= resp_code(rd_sel);
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Registered control outputs
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		module_enable_o <= 1'b0;
		pingpong_reset_o <= 1'b0;
		resume_o <= 1'b0;
		bus_reset_o <= 1'b0;
		host_mode_o <= 1'b0;
		host_logic_reset_o <= 1'b0;
		packet_disable_o <= 1'b0;
		low_speed_next_token_o <= 1'b0;
		device_address_o <= 7'h00;
	end else begin
		module_enable_o <= ctrl_q[`UCAF_CTRL_ENABLE] && !ctrl_q[`UCAF_CTRL_HOST];
		// Held while the bit stays set; a zero write never pulses it
		pingpong_reset_o <= ctrl_q[`UCAF_CTRL_PPRST];
		resume_o <= ctrl_q[`UCAF_CTRL_RESUME];
		bus_reset_o <= ctrl_q[`UCAF_CTRL_BUSRST];
		host_mode_o <= ctrl_q[`UCAF_CTRL_HOST];
		host_logic_reset_o <= host_reset_pulse;
		packet_disable_o <= ctrl_q[`UCAF_CTRL_PACKET_PROCESSING_DISABLE] && !ctrl_q[`UCAF_CTRL_HOST];
		low_speed_next_token_o <= addr_q[`UCAF_ADDR_LS];
		device_address_o <= addr_q[`UCAF_ADDR_DEV_HI:`UCAF_ADDR_DEV_LO];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Host timing; a host toggle restarts the frame timer and cancels an EOP
usbcaf_host_timer #(
	.SOF_CYC(SOF_CYC),
	.EOP_CYC(`UCAF_LS_EOP_CYC)
) u_timer (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.host_reset_i(host_reset_pulse),
	.sof_enable_i(ctrl_q[`UCAF_CTRL_HOST] && ctrl_q[`UCAF_CTRL_ENABLE]),
	.resume_fall_i(resume_fall),
	.sof_tick_o(sof_tick_o),
	.ls_eop_o(ls_eop_o)
);

endmodule
`default_nettype wire

// ==== dv/ucaf_usb_model.sv ====
/*
 * Bus-side stand-in for the USB packet engine: SOF and SETUP pulses,
 * token busy and live line state, each one cycle after the bench asks.
 * Assumes requests are driven on the rising edge of clock_i.
 */
`timescale 1ns/1ns
`default_nettype none
module ucaf_usb_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Bench requests
	input wire logic sof_go_i,
	input wire logic [10:0] frame_i,
	input wire logic setup_go_i,
	input wire logic busy_i,
	input wire logic se0_i,
	// Engine view
	output logic sof_rx_o,
	output logic [10:0] sof_frame_o,
	output logic setup_rx_o,
	output logic token_busy_o,
	output logic jstate_o,
	output logic se0_o
);
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		sof_rx_o <= 1'b0;
		sof_frame_o <= 11'h000;
		setup_rx_o <= 1'b0;
		token_busy_o <= 1'b0;
		jstate_o <= 1'b0;
		se0_o <= 1'b0;
	end else begin
		sof_rx_o <= sof_go_i;
		// Frame lines mean nothing between pulses, so they keep moving
		sof_frame_o <= sof_go_i ? frame_i : ~sof_frame_o;
		setup_rx_o <= setup_go_i;
		token_busy_o <= busy_i;
		se0_o <= se0_i;
		jstate_o <= ~se0_i;
	end
end
endmodule
`default_nettype wire

// ==== dv/ucaf_props.sv ====
/*
 * Port checker for the control, address and frame register slice.
 * Assumes aligned AXI4-Lite writes and no host toggle during an EOP.
 */
`timescale 1ns/1ns
`default_nettype none
`include "usbcaf_consts.vh"
module ucaf_props #(
	parameter [31:0] SOF_CYC = 32'd20
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// Engine side
	input wire logic setup_rx_i,
	input wire logic module_enable_o,
	input wire logic pingpong_reset_o,
	input wire logic resume_o,
	input wire logic host_mode_o,
	input wire logic host_logic_reset_o,
	input wire logic packet_disable_o,
	input wire logic low_speed_next_token_o,
	input wire logic [6:0] device_address_o,
	input wire logic sof_tick_o,
	input wire logic ls_eop_o
);
logic [7:0] aw_q;
logic [7:0] wd_q;
logic ws_q;
logic armed_q;
int gap_q;
int eop_q;
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		aw_q <= 8'h00;
		wd_q <= 8'h00;
		ws_q <= 1'b0;
		armed_q <= 1'b0;
		gap_q <= 0;
		eop_q <= 0;
	end else begin
		if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
		if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[0];
		// Gap is only meaningful between ticks of one unbroken host session
		armed_q <= (host_logic_reset_o || !host_mode_o) ? 1'b0 : (armed_q | sof_tick_o);
		gap_q <= sof_tick_o ? 1 : gap_q + 1;
		eop_q <= ls_eop_o ? eop_q + 1 : 0;
	end
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clock_i); endclocking
default disable iff (rst_i);
wr_ctrl_a: assert property ($rose(s_axi_bvalid) && ws_q && aw_q == `UCAF_OFF_CTRL |=>
	pingpong_reset_o == wd_q[1] && module_enable_o == (wd_q[0] & ~wd_q[3]))
	else $error("control write not reflected");
wr_speed_a: assert property ($rose(s_axi_bvalid) && ws_q && aw_q == `UCAF_OFF_ADDR |=>
	low_speed_next_token_o == wd_q[7]) else $error("speed bit not reflected");
wr_device_address_field_a: assert property ($rose(s_axi_bvalid) && ws_q && aw_q == `UCAF_OFF_ADDR |=>
	device_address_o == wd_q[6:0]) else $error("device address not reflected");
host_reset_a: assert property ($changed(host_mode_o) |-> ##[0:1] host_logic_reset_o)
	else $error("host toggle without host reset");
host_modes_a: assert property (host_mode_o |-> !module_enable_o && !packet_disable_o)
	else $error("device-mode output active in host mode");
setup_hold_a: assert property (setup_rx_i && module_enable_o |-> ##[1:2] packet_disable_o)
	else $error("SETUP did not disable packets");
sof_gap_a: assert property (sof_tick_o && armed_q |-> gap_q == SOF_CYC)
	else $error("frame-start spacing wrong");
sof_off_a: assert property (!host_mode_o [*3] |-> !sof_tick_o)
	else $error("frame start outside host mode");
eop_start_a: assert property ($fell(resume_o) && host_mode_o |-> ##[0:2] ls_eop_o)
	else $error("no EOP after resume");
eop_len_a: assert property ($fell(ls_eop_o) |-> eop_q == `UCAF_LS_EOP_CYC)
	else $error("EOP length wrong");
rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
	else $error("upper read bits not zero");
cover property (ls_eop_o);
cover property (sof_tick_o && armed_q);
cover property (setup_rx_i && module_enable_o);
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
/*
 * Self-checking bench for usbcaf_regs with an AXI4-Lite master and
 * the USB engine model. Assumes a shortened frame-start count.
 */
`timescale 1ns/1ns
`default_nettype none
`include "usbcaf_consts.vh"
module tb;
localparam [31:0] SOF_CYC = 32'd20;
logic clock_i, rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata, v;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic jstate_i, se0_i, token_busy_i, setup_rx_i, sof_rx_i, sof_go, setup_go, busy_go, se0_go;
logic [10:0] sof_frame_i, frame_go;
logic module_enable_o, pingpong_reset_o, resume_o, bus_reset_o, host_mode_o, host_logic_reset_o;
logic packet_disable_o, low_speed_next_token_o, sof_tick_o, ls_eop_o;
logic [6:0] device_address_o;
int failures, checked, seed, i, n;
usbcaf_regs #(.SOF_CYC(SOF_CYC)) usbcaf_regs_i (.*);
ucaf_usb_model ucaf_usb_model_i (.clock_i(clock_i), .rst_i(rst_i), .sof_go_i(sof_go),
	.frame_i(frame_go), .setup_go_i(setup_go), .busy_i(busy_go), .se0_i(se0_go),
	.sof_rx_o(sof_rx_i), .sof_frame_o(sof_frame_i), .setup_rx_o(setup_rx_i),
	.token_busy_o(token_busy_i), .jstate_o(jstate_i), .se0_o(se0_i));
////////////////////////////////////////////////////////////////////////////////
task automatic close_out;
	$display("Counts: %0d checks, %0d failures", checked, failures);
	if (failures == 0 && checked > 0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	checked++;
	if (got !== exp) begin
		failures++;
		$display("Error at %0t: saw %h, wanted %h", $time, got, exp);
	end
endtask
function automatic logic [31:0] low_byte(input logic [31:0] x);
	return {24'h000000, x[7:0]};
endfunction
function automatic logic [31:0] high_bits(input logic [10:0] f);
	return {29'h00000000, f[10:8]};
endfunction
task automatic to_fail;
	failures++;
	close_out();
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
	int k;
	k = 0;
	@(posedge clock_i);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do begin
		@(posedge clock_i);
		k++;
		if (s_axi_awready) s_axi_awvalid <= 1'b0;
		if (s_axi_wready) s_axi_wvalid <= 1'b0;
	end while (s_axi_bvalid !== 1'b1 && k < 50);
	s_axi_bready <= 1'b0;
	if (k >= 50) to_fail();
	chk(s_axi_bresp, `UCAF_RESP_OKAY);
	// Control outputs trail the register write by one edge
	@(posedge clock_i);
endtask
task automatic rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
	int k;
	k = 0;
	@(posedge clock_i);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do begin
		@(posedge clock_i);
		k++;
		if (s_axi_arready) s_axi_arvalid <= 1'b0;
	end while (s_axi_rvalid !== 1'b1 && k < 50);
	s_axi_rready <= 1'b0;
	if (k >= 50) to_fail();
	chk(s_axi_rdata, d);
	chk(s_axi_rresp, r);
endtask
task automatic wait_tick(output int k);
	k = 0;
	do begin
		@(posedge clock_i);
		k++;
	end while (sof_tick_o !== 1'b1 && k < 200);
	if (k >= 200) to_fail();
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	clock_i = 1'b0;
	forever #5 clock_i = ~clock_i;
end
initial begin
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
	{sof_go, setup_go, busy_go, se0_go} = 4'h0;
	s_axi_awaddr = 8'h00;
	s_axi_araddr = 8'h00;
	s_axi_wdata = 32'h00000000;
	s_axi_wstrb = 4'hF;
	frame_go = 11'h000;
	failures = 0;
	checked = 0;
	seed = 14134;
	rst_i = 1'b1;
	repeat (16) @(posedge clock_i);
	rst_i <= 1'b0;
	rchk(`UCAF_OFF_CTRL, 32'h00000080, `UCAF_RESP_OKAY);
	rchk(`UCAF_OFF_ADDR, 32'h00000000, `UCAF_RESP_OKAY);
	rchk(`UCAF_OFF_FRAME_LOW_BYTE, 32'h00000000, `UCAF_RESP_OKAY);
	rchk(`UCAF_OFF_FRAME_HIGH_BITS, 32'h00000000, `UCAF_RESP_OKAY);
	rchk(8'h10, 32'h00000000, `UCAF_RESP_SLVERR);
	$display("reset values done");
	for (i = 0; i < 8; i++) begin
		v = $random(seed);
		if (i < 2) v[7:0] = (i == 0) ? 8'hFF : 8'h80;
		wr(`UCAF_OFF_ADDR, v);
		rchk(`UCAF_OFF_ADDR, low_byte(v), `UCAF_RESP_OKAY);
		chk(low_speed_next_token_o, v[7]);
		chk(device_address_o, v[6:0]);
	end
	$display("address test done");
	se0_go <= 1'b1;
	wr(`UCAF_OFF_CTRL, 32'h00000013);
	chk(module_enable_o, 1'b1);
	chk(pingpong_reset_o, 1'b1);
	chk(bus_reset_o, 1'b1);
	rchk(`UCAF_OFF_CTRL, 32'h00000053, `UCAF_RESP_OKAY);
	wr(`UCAF_OFF_CTRL, 32'h00000001);
	chk(pingpong_reset_o, 1'b0);
	chk(bus_reset_o, 1'b0);
	setup_go <= 1'b1;
	@(posedge clock_i);
	setup_go <= 1'b0;
	repeat (3) @(posedge clock_i);
	chk(packet_disable_o, 1'b1);
	rchk(`UCAF_OFF_CTRL, 32'h00000061, `UCAF_RESP_OKAY);
	wr(`UCAF_OFF_CTRL, 32'h00000001);
	chk(packet_disable_o, 1'b0);
	$display("device control test done");
	for (i = 0; i < 6; i++) begin
		v = (i == 0) ? 32'h000007FF : $random(seed);
		sof_go <= 1'b1;
		frame_go <= v[10:0];
		@(posedge clock_i);
		sof_go <= 1'b0;
		wr(`UCAF_OFF_FRAME_LOW_BYTE, 32'h000000FF);
		rchk(`UCAF_OFF_FRAME_LOW_BYTE, low_byte(v), `UCAF_RESP_OKAY);
		rchk(`UCAF_OFF_FRAME_HIGH_BITS, high_bits(v[10:0]), `UCAF_RESP_OKAY);
	end
	$display("frame number test done");
	wr(`UCAF_OFF_CTRL, 32'h00000009);
	chk(module_enable_o, 1'b0);
	chk(host_logic_reset_o, 1'b1);
	wait_tick(n);
	wait_tick(n);
	chk(n, SOF_CYC);
	busy_go <= 1'b1;
	rchk(`UCAF_OFF_CTRL, 32'h00000069, `UCAF_RESP_OKAY);
	busy_go <= 1'b0;
	rchk(`UCAF_OFF_CTRL, 32'h00000049, `UCAF_RESP_OKAY);
	wr(`UCAF_OFF_CTRL, 32'h0000000D);
	chk(resume_o, 1'b1);
	chk(host_logic_reset_o, 1'b0);
	wr(`UCAF_OFF_CTRL, 32'h00000009);
	n = 0;
	while (ls_eop_o !== 1'b1 && n < 50) begin
		@(posedge clock_i);
		n++;
	end
	if (n >= 50) to_fail();
	n = 0;
	while (ls_eop_o === 1'b1 && n < 300) begin
		@(posedge clock_i);
		n++;
	end
	chk(n, `UCAF_LS_EOP_CYC);
	wr(`UCAF_OFF_CTRL, 32'h00000000);
	chk(host_mode_o, 1'b0);
	chk(host_logic_reset_o, 1'b1);
	n = 0;
	repeat (3 * SOF_CYC) begin
		@(posedge clock_i);
		if (sof_tick_o !== 1'b0) n++;
	end
	chk(n, 0);
	$display("host test done");
	close_out();
end
endmodule
bind usbcaf_regs ucaf_props #(.SOF_CYC(SOF_CYC)) ucaf_props_i (.*);
`default_nettype wire
